// >>> shared/gtf_pkg.sv
// Shared constants for the generic transport framer ends
package gtf_pkg;
  // ************************************************************
  // Frame timing
  // ************************************************************
  localparam int FRAME_PERIOD_MS = 24;
  localparam int CLK_KHZ         = 200_000;
  localparam int FRAME_CYCLES    = FRAME_PERIOD_MS * CLK_KHZ;
  localparam int FRAME_LEN_DEF   = 768;
  localparam int BIT_DIV_DEF     = 780;
  // ************************************************************
  // Frame layout, positions counted from the error level byte
  // ************************************************************
  localparam logic [15:0] POS_ERR      = 16'h0000;
  localparam logic [15:0] POS_SYNC_0   = 16'h0001;
  localparam logic [15:0] POS_SYNC_1   = 16'h0002;
  localparam logic [15:0] POS_SYNC_2   = 16'h0003;
  localparam logic [15:0] POS_DLEN_HI  = 16'h0004;
  localparam logic [15:0] POS_DLEN_LO  = 16'h0005;
  localparam logic [15:0] POS_CLEN_HI  = 16'h0006;
  localparam logic [15:0] POS_CLEN_LO  = 16'h0007;
  localparam logic [15:0] HDR_LEN      = 16'h0008;
  localparam logic [7:0]  FILL_BYTE    = 8'h55;
  // Sync words with the first sent byte in the low bits
  localparam logic [23:0] SYNC_A       = 24'hCA_901F;
  localparam logic [23:0] SYNC_B       = 24'h35_6FE0;
  // ************************************************************
  // Lock control and error level reset value
  // ************************************************************
  localparam logic [1:0]  LOCK_GOOD    = 2'h3;
  localparam logic [1:0]  LOSS_BAD     = 2'h2;
  localparam logic [1:0]  ERR_RST      = 2'h0;
endpackage : gtf_pkg

// >>> shared/gtf_link_if.sv
// Serial link between the device framer and its peer
`timescale 1ns/1ps
`default_nettype none
interface gtf_link_if;
  logic dev_bit;
  logic dev_stb;
  logic peer_bit;
  logic peer_stb;
  modport dev  (output dev_bit, output dev_stb, input peer_bit, input peer_stb);
  modport peer (input dev_bit, input dev_stb, output peer_bit, output peer_stb);
endinterface : gtf_link_if
`default_nettype wire

// >>> logic/gtf_dev_framer.sv
// Device end: frame builder and frame parser with lock and error level
// What this block does
// - Constant-length frame every 24 ms period
// - Sync, header, data, control, tail order
// - Bytes in order, bit 0 first
// - Error byte then 24-bit sync word
// - Error byte from stream error status
// - Error level only 0 to 3
// - CRC failures raise level to 1/2/3
// - Receiver lowers error level only from received error byte
// - Error level ignored when data length zero
// - Sync word alternates between complement patterns
// - Lock after three alternating sync words
// - Lose lock after two bad syncs
// - Header holds data and control lengths
// - Lengths not clamped to fit in frame
// - Zero data length means no data
// - Zero control length means no control
// - Data section follows header, payload first
// - Data fill bytes are 55 hex
// - Control section follows data section
// - Tail fill bytes are 55 hex
// - Receiver ignores tail fill content
// - Flag lengths repeated unchanged between frames
`timescale 1ns/1ps
`default_nettype none
module gtf_dev_framer #(
  parameter int FRAME_LEN = gtf_pkg::FRAME_LEN_DEF,
  parameter int BIT_DIV   = gtf_pkg::BIT_DIV_DEF,
  parameter int FRAME_CYC = gtf_pkg::FRAME_CYCLES
) (
  input  wire logic        clock,
  input  wire logic        nrst,
  gtf_link_if.dev          link,
  input  wire logic [15:0] data_section_length,
  input  wire logic [15:0] control_section_length,
  input  wire logic [15:0] payload_length,
  input  wire logic [1:0]  stream_err_level,
  input  wire logic [7:0]  stream_payload,
  input  wire logic [7:0]  control_payload,
  output var  logic [15:0] tx_pos,
  input  wire logic        crc_valid,
  input  wire logic        crc_stream_characterisation_fail,
  input  wire logic        crc_end_of_header_fail,
  output var  logic        rx_locked,
  output var  logic        rx_frame_start,
  output var  logic        rx_byte_stb,
  output var  logic [7:0]  rx_byte,
  output var  logic [15:0] rx_idx,
  output var  logic        rx_data_q,
  output var  logic        rx_ctrl_q,
  output var  logic        rx_tail_q,
  output var  logic [1:0]  rx_err_level,
  output var  logic        rx_err_valid,
  output var  logic [15:0] rx_data_len,
  output var  logic [15:0] rx_ctrl_len,
  output var  logic        rx_len_stable
);
  generate
    if (FRAME_LEN < 8 || FRAME_LEN > 65535 || BIT_DIV < 1 || FRAME_LEN * 8 * BIT_DIV > FRAME_CYC) begin : g_bad
      $error("Frame does not fit its period");
    end
  endgenerate
  typedef struct packed {
    logic [31:0] ftim;
    logic [15:0] bdiv;
    logic        tx_act;
    logic [15:0] tx_pos;
    logic [2:0]  tx_bc;
    logic [7:0]  tx_sh;
    logic        tx_alt;
    logic        tx_bit;
    logic        tx_stb;
    logic [15:0] tx_dlen;
    logic [15:0] tx_clen;
    logic [15:0] tx_plen;
    logic [1:0]  tx_err;
    logic [23:0] win;
    logic        rx_al;
    logic [15:0] rx_pos;
    logic [2:0]  rx_bc;
    logic [7:0]  rx_sh;
    logic        exp_b;
    logic [1:0]  good;
    logic [1:0]  bad;
    logic        locked;
    logic [15:0] dnew;
    logic [7:0]  chi;
    logic [15:0] dlen;
    logic [15:0] clen;
    logic        same;
    logic [1:0]  err;
    logic        fstart;
    logic        bstb;
    logic [7:0]  byte_v;
    logic [15:0] idx;
    logic        q_data;
    logic        q_ctrl;
    logic        q_tail;
    logic        err_ok;
  } gtf_dev_st_t;
  localparam logic [15:0] LAST_POS = 16'(FRAME_LEN - 1);
  localparam logic [31:0] FTIM_TOP = 32'(FRAME_CYC - 1);
  localparam logic [15:0] BDIV_TOP = 16'(BIT_DIV - 1);
  gtf_dev_st_t q_ff;
  gtf_dev_st_t nxt_q;
  logic [7:0]  tx_sel;
  logic [15:0] tx_b;
  logic [7:0]  tx_cur;
  logic [23:0] win_n;
  logic [7:0]  sh_n;
  logic [15:0] rx_b;
  logic [1:0]  crc_lvl;
  // ************************************************************
  // Transmit byte selection
  // ************************************************************
  always_comb begin
    tx_b = q_ff.tx_pos - gtf_pkg::HDR_LEN;
    unique case (q_ff.tx_pos)
      gtf_pkg::POS_ERR:     tx_sel = {6'h00, q_ff.tx_err};
      gtf_pkg::POS_SYNC_0:  tx_sel = q_ff.tx_alt ? gtf_pkg::SYNC_B[7:0] : gtf_pkg::SYNC_A[7:0];
      gtf_pkg::POS_SYNC_1:  tx_sel = q_ff.tx_alt ? gtf_pkg::SYNC_B[15:8] : gtf_pkg::SYNC_A[15:8];
      gtf_pkg::POS_SYNC_2:  tx_sel = q_ff.tx_alt ? gtf_pkg::SYNC_B[23:16] : gtf_pkg::SYNC_A[23:16];
      gtf_pkg::POS_DLEN_HI: tx_sel = q_ff.tx_dlen[15:8];
      gtf_pkg::POS_DLEN_LO: tx_sel = q_ff.tx_dlen[7:0];
      gtf_pkg::POS_CLEN_HI: tx_sel = q_ff.tx_clen[15:8];
      gtf_pkg::POS_CLEN_LO: tx_sel = q_ff.tx_clen[7:0];
      default: begin
        if (tx_b < q_ff.tx_plen && tx_b < q_ff.tx_dlen) begin
          tx_sel = stream_payload;
        end else if (tx_b < q_ff.tx_dlen) begin
          tx_sel = gtf_pkg::FILL_BYTE;
        end else if ({1'b0, tx_b} < {1'b0, q_ff.tx_dlen} + {1'b0, q_ff.tx_clen}) begin
          tx_sel = control_payload;
        end else begin
          tx_sel = gtf_pkg::FILL_BYTE;
        end
      end
    endcase
  end
  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    nxt_q        = q_ff;
    nxt_q.tx_stb = 1'b0;
    nxt_q.fstart = 1'b0;
    nxt_q.bstb   = 1'b0;
    tx_cur       = (q_ff.tx_bc == 3'h0) ? tx_sel : q_ff.tx_sh;
    win_n        = {link.peer_bit, q_ff.win[23:1]};
    sh_n         = {link.peer_bit, q_ff.rx_sh[7:1]};
    rx_b         = q_ff.rx_pos - gtf_pkg::HDR_LEN;
    crc_lvl      = {crc_end_of_header_fail, crc_stream_characterisation_fail};
    // Frame period; lengths are latched once so a frame never changes shape midway
    nxt_q.ftim = (q_ff.ftim == 32'h0000_0000) ? FTIM_TOP : q_ff.ftim - 32'h0000_0001;
    if (q_ff.ftim == 32'h0000_0000) begin
      nxt_q.tx_act  = 1'b1;
      nxt_q.tx_pos  = 16'h0000;
      nxt_q.tx_bc   = 3'h0;
      nxt_q.bdiv    = 16'h0000;
      nxt_q.tx_alt  = ~q_ff.tx_alt;
      nxt_q.tx_dlen = data_section_length;
      nxt_q.tx_clen = control_section_length;
      nxt_q.tx_plen = payload_length;
      nxt_q.tx_err  = stream_err_level;
    end else if (q_ff.tx_act) begin
      nxt_q.bdiv = (q_ff.bdiv == 16'h0000) ? BDIV_TOP : q_ff.bdiv - 16'h0001;
      if (q_ff.bdiv == 16'h0000) begin
        nxt_q.tx_stb = 1'b1;
        nxt_q.tx_bit = tx_cur[0];
        nxt_q.tx_sh  = {1'b0, tx_cur[7:1]};
        nxt_q.tx_bc  = q_ff.tx_bc + 3'h1;
        if (q_ff.tx_bc == 3'h7) begin
          nxt_q.tx_pos = q_ff.tx_pos + 16'h0001;
          if (q_ff.tx_pos == LAST_POS) nxt_q.tx_act = 1'b0;
        end
      end
    end
    // CRC failures may only raise the error level, and only while a data section is present
    if (crc_valid && q_ff.dlen != 16'h0000 && crc_lvl > q_ff.err) begin
      nxt_q.err = crc_lvl;
    end
    if (link.peer_stb) begin
      nxt_q.win = win_n;
      if (!q_ff.rx_al) begin
        // Hunting: any sync pattern aligns the byte counter
        if (win_n == gtf_pkg::SYNC_A || win_n == gtf_pkg::SYNC_B) begin
          nxt_q.rx_al  = 1'b1;
          nxt_q.rx_pos = gtf_pkg::POS_DLEN_HI;
          nxt_q.rx_bc  = 3'h0;
          nxt_q.exp_b  = (win_n == gtf_pkg::SYNC_A);
          nxt_q.good   = 2'h1;
        end
      end else begin
        nxt_q.rx_sh = sh_n;
        nxt_q.rx_bc = q_ff.rx_bc + 3'h1;
        if (q_ff.rx_bc == 3'h7) begin
          nxt_q.rx_pos = (q_ff.rx_pos == LAST_POS) ? 16'h0000 : q_ff.rx_pos + 16'h0001;
          if (q_ff.rx_pos == gtf_pkg::POS_ERR) begin
            nxt_q.err    = sh_n[1:0];
            nxt_q.fstart = q_ff.locked;
          end
          if (q_ff.rx_pos == gtf_pkg::POS_SYNC_2) begin
            if (win_n == (q_ff.exp_b ? gtf_pkg::SYNC_B : gtf_pkg::SYNC_A)) begin
              nxt_q.exp_b = ~q_ff.exp_b;
              nxt_q.bad   = 2'h0;
              nxt_q.good  = (q_ff.good == gtf_pkg::LOCK_GOOD) ? q_ff.good : q_ff.good + 2'h1;
              if (q_ff.good + 2'h1 == gtf_pkg::LOCK_GOOD) begin
                nxt_q.locked = 1'b1;
              end
            end else if (q_ff.locked && q_ff.bad + 2'h1 != gtf_pkg::LOSS_BAD) begin
              // One miss is tolerated; keep the expected pattern marching
              nxt_q.exp_b = ~q_ff.exp_b;
              nxt_q.bad   = q_ff.bad + 2'h1;
            end else begin
              nxt_q.locked = 1'b0;
              nxt_q.rx_al  = 1'b0;
              nxt_q.good   = 2'h0;
              nxt_q.bad    = 2'h0;
            end
          end
          if (q_ff.rx_pos == gtf_pkg::POS_DLEN_HI) nxt_q.dnew[15:8] = sh_n;
          if (q_ff.rx_pos == gtf_pkg::POS_DLEN_LO) nxt_q.dnew[7:0] = sh_n;
          if (q_ff.rx_pos == gtf_pkg::POS_CLEN_HI) nxt_q.chi = sh_n;
          if (q_ff.rx_pos == gtf_pkg::POS_CLEN_LO) begin
            nxt_q.same = (q_ff.dnew == q_ff.dlen) && ({q_ff.chi, sh_n} == q_ff.clen);
            nxt_q.dlen = q_ff.dnew;
            nxt_q.clen = {q_ff.chi, sh_n};
          end
          if (q_ff.rx_pos >= gtf_pkg::HDR_LEN && q_ff.locked) begin
            nxt_q.bstb   = 1'b1;
            nxt_q.byte_v = sh_n;
            nxt_q.idx    = rx_b;
            nxt_q.q_data = rx_b < q_ff.dlen;
            nxt_q.q_ctrl = (rx_b >= q_ff.dlen) && ({1'b0, rx_b} < {1'b0, q_ff.dlen} + {1'b0, q_ff.clen});
            // Tail content is only flagged, never interpreted
            nxt_q.q_tail = {1'b0, rx_b} >= {1'b0, q_ff.dlen} + {1'b0, q_ff.clen};
          end
        end
      end
    end
    nxt_q.err_ok = nxt_q.locked && (nxt_q.dlen != 16'h0000);
  end
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      q_ff     <= '0;
      q_ff.err <= gtf_pkg::ERR_RST;
    end else begin
      q_ff <= nxt_q;
    end
  end
  // ************************************************************
  // Outputs
  // ************************************************************
  assign link.dev_bit   = q_ff.tx_bit;
  assign link.dev_stb   = q_ff.tx_stb;
  assign tx_pos         = q_ff.tx_pos;
  assign rx_locked      = q_ff.locked;
  assign rx_frame_start = q_ff.fstart;
  assign rx_byte_stb    = q_ff.bstb;
  assign rx_byte        = q_ff.byte_v;
  assign rx_idx         = q_ff.idx;
  assign rx_data_q      = q_ff.q_data;
  assign rx_ctrl_q      = q_ff.q_ctrl;
  assign rx_tail_q      = q_ff.q_tail;
  assign rx_err_level   = q_ff.err;
  assign rx_err_valid   = q_ff.err_ok;
  assign rx_data_len    = q_ff.dlen;
  assign rx_ctrl_len    = q_ff.clen;
  assign rx_len_stable  = q_ff.same;
endmodule : gtf_dev_framer
`default_nettype wire

// >>> logic/gtf_peer_framer.sv
// Peer end: frame source toward the device and sync watcher on the device stream
`timescale 1ns/1ps
`default_nettype none
module gtf_peer_framer #(
  parameter int FRAME_LEN = gtf_pkg::FRAME_LEN_DEF,
  parameter int BIT_DIV   = gtf_pkg::BIT_DIV_DEF,
  parameter int FRAME_CYC = gtf_pkg::FRAME_CYCLES
) (
  input  wire logic        clock,
  input  wire logic        nrst,
  gtf_link_if.peer         link,
  input  wire logic [15:0] data_section_length,
  input  wire logic [15:0] control_section_length,
  input  wire logic [1:0]  err_level,
  input  wire logic [7:0]  section_byte,
  output var  logic [15:0] pos,
  output var  logic        sync_seen
);
  generate
    if (FRAME_LEN < 8 || FRAME_LEN > 65535 || BIT_DIV < 1 || FRAME_LEN * 8 * BIT_DIV > FRAME_CYC) begin : g_bad
      $error("Frame does not fit its period");
    end
  endgenerate

  typedef struct packed {
    logic [31:0] ftim;
    logic [15:0] bdiv;
    logic        act;
    logic [15:0] pos;
    logic [2:0]  bc;
    logic [7:0]  sh;
    logic        alt;
    logic        bit_v;
    logic        stb;
    logic [15:0] dlen;
    logic [15:0] clen;
    logic [1:0]  err;
    logic [23:0] win;
    logic        seen;
  } gtf_peer_st_t;

  localparam logic [15:0] LAST_POS = 16'(FRAME_LEN - 1);
  localparam logic [16:0] ROOM     = 17'(FRAME_LEN - 8);
  localparam logic [31:0] FTIM_TOP = 32'(FRAME_CYC - 1);
  localparam logic [15:0] BDIV_TOP = 16'(BIT_DIV - 1);

  gtf_peer_st_t q_ff;
  gtf_peer_st_t nxt_q;

  logic [16:0] dl_c;
  logic [16:0] cl_c;
  logic [7:0]  sel;
  logic [15:0] b;
  logic [7:0]  cur;
  logic [23:0] win_n;

  always_comb begin
    nxt_q      = q_ff;
    nxt_q.stb  = 1'b0;
    nxt_q.seen = 1'b0;
    // Clamp lengths so the sections always fit the frame
    dl_c = ({1'b0, data_section_length} > ROOM) ? ROOM : {1'b0, data_section_length};
    cl_c = ({1'b0, control_section_length} > ROOM - dl_c) ? ROOM - dl_c : {1'b0, control_section_length};
    b    = q_ff.pos - gtf_pkg::HDR_LEN;
    unique case (q_ff.pos)
      gtf_pkg::POS_ERR:     sel = {6'h00, q_ff.err};
      gtf_pkg::POS_SYNC_0:  sel = q_ff.alt ? gtf_pkg::SYNC_B[7:0] : gtf_pkg::SYNC_A[7:0];
      gtf_pkg::POS_SYNC_1:  sel = q_ff.alt ? gtf_pkg::SYNC_B[15:8] : gtf_pkg::SYNC_A[15:8];
      gtf_pkg::POS_SYNC_2:  sel = q_ff.alt ? gtf_pkg::SYNC_B[23:16] : gtf_pkg::SYNC_A[23:16];
      gtf_pkg::POS_DLEN_HI: sel = q_ff.dlen[15:8];
      gtf_pkg::POS_DLEN_LO: sel = q_ff.dlen[7:0];
      gtf_pkg::POS_CLEN_HI: sel = q_ff.clen[15:8];
      gtf_pkg::POS_CLEN_LO: sel = q_ff.clen[7:0];
      default: begin
        sel = ({1'b0, b} < {1'b0, q_ff.dlen} + {1'b0, q_ff.clen}) ? section_byte : gtf_pkg::FILL_BYTE;
      end
    endcase
    cur = (q_ff.bc == 3'h0) ? sel : q_ff.sh;
    nxt_q.ftim = (q_ff.ftim == 32'h0000_0000) ? FTIM_TOP : q_ff.ftim - 32'h0000_0001;
    if (q_ff.ftim == 32'h0000_0000) begin
      nxt_q.act  = 1'b1;
      nxt_q.pos  = 16'h0000;
      nxt_q.bc   = 3'h0;
      nxt_q.bdiv = 16'h0000;
      nxt_q.alt  = ~q_ff.alt;
      nxt_q.dlen = dl_c[15:0];
      nxt_q.clen = cl_c[15:0];
      nxt_q.err  = err_level;
    end else if (q_ff.act) begin
      nxt_q.bdiv = (q_ff.bdiv == 16'h0000) ? BDIV_TOP : q_ff.bdiv - 16'h0001;
      if (q_ff.bdiv == 16'h0000) begin
        nxt_q.stb   = 1'b1;
        nxt_q.bit_v = cur[0];
        nxt_q.sh    = {1'b0, cur[7:1]};
        nxt_q.bc    = q_ff.bc + 3'h1;
        if (q_ff.bc == 3'h7) begin
          nxt_q.pos = q_ff.pos + 16'h0001;
          if (q_ff.pos == LAST_POS) begin
            nxt_q.act = 1'b0;
          end
        end
      end
    end
    win_n = {link.dev_bit, q_ff.win[23:1]};
    if (link.dev_stb) begin
      nxt_q.win  = win_n;
      nxt_q.seen = (win_n == gtf_pkg::SYNC_A) || (win_n == gtf_pkg::SYNC_B);
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      q_ff <= '0;
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign link.peer_bit = q_ff.bit_v;
  assign link.peer_stb = q_ff.stb;
  assign pos           = q_ff.pos;
  assign sync_seen     = q_ff.seen;
endmodule : gtf_peer_framer
`default_nettype wire

// >>> bench/gtf_link_checker.sv
// Concurrent checks on the serial link between the two framer ends
`timescale 1ns/1ps
`default_nettype none
module gtf_link_checker #(
  parameter int FRAME_LEN = 16,
  parameter int BIT_DIV   = 2,
  parameter int FRAME_CYC = 2000
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic dev_bit,
  input wire logic dev_stb,
  input wire logic peer_bit,
  input wire logic peer_stb
);
  // ********
  // Frame tracking
  // ********
  localparam int          LAST  = FRAME_LEN * 8 - 1;
  localparam int          IDLE  = FRAME_CYC - LAST * BIT_DIV - 1;
  localparam logic [23:0] PAT_A = 24'hCA_901F;
  localparam logic [23:0] PAT_B = 24'h35_6FE0;
  logic [15:0] bits_ff;
  logic [15:0] gap_ff;
  logic [23:0] sh_ff;
  logic [23:0] last_ff;
  logic        seen_ff;
  logic        run_ff;
  logic        sync_end;
  logic [23:0] word;
  // First sent bit ends up lowest, matching the byte order on the wire
  assign word     = {dev_bit, sh_ff[23:1]};
  assign sync_end = dev_stb && bits_ff == 16'h001F;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      bits_ff <= 16'h0000;
      gap_ff  <= 16'h0000;
      sh_ff   <= 24'h00_0000;
      last_ff <= 24'h00_0000;
      seen_ff <= 1'b0;
      run_ff  <= 1'b0;
    end else begin
      gap_ff <= dev_stb ? 16'h0000 : gap_ff + 16'h0001;
      if (dev_stb) begin
        bits_ff <= (bits_ff == 16'(LAST)) ? 16'h0000 : bits_ff + 16'h0001;
        sh_ff   <= word;
        run_ff  <= 1'b1;
      end
      if (sync_end) begin
        last_ff <= word;
        seen_ff <= 1'b1;
      end
    end
  end
  // ********
  // Assertions
  // ********
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  a_dev_stb_pulse: assert property (dev_stb |=> !dev_stb)
    else $error("device strobe too long");
  a_peer_stb_pulse: assert property (peer_stb |=> !peer_stb)
    else $error("peer strobe too long");
  a_dev_bit_hold: assert property ($changed(dev_bit) |-> dev_stb)
    else $error("device bit moved between strobes");
  a_peer_bit_hold: assert property ($changed(peer_bit) |-> peer_stb)
    else $error("peer bit moved between strobes");
  a_bit_pace: assert property (dev_stb && bits_ff != 16'h0000 |-> gap_ff == 16'(BIT_DIV - 1))
    else $error("bit spacing wrong");
  a_frame_pace: assert property (dev_stb && bits_ff == 16'h0000 && run_ff |-> gap_ff == 16'(IDLE))
    else $error("frame spacing wrong");
  a_sync_pattern: assert property (sync_end |-> word == PAT_A || word == PAT_B)
    else $error("sync word not a known pattern");
  a_sync_alt: assert property (sync_end && seen_ff |-> word == ~last_ff)
    else $error("sync word did not alternate");
  a_sync_first: assert property (sync_end && !seen_ff |-> word == PAT_B)
    else $error("first sync word wrong");
  a_err_range: assert property (dev_stb && bits_ff >= 16'h0002 && bits_ff <= 16'h0007 |-> !dev_bit)
    else $error("error byte upper bits set");
endmodule : gtf_link_checker
`default_nettype wire

// >>> bench/generic_transport_framer_tb.sv
// Bench joining device and peer framer ends, plus a device copy on a damaged link
`timescale 1ns/1ps
`default_nettype none
module generic_transport_framer_tb;
  // ********
  // Signals
  // ********
  localparam int FL = 16;
  localparam int BD = 2;
  localparam int FC = 2000;
  logic        clock = 1'b0;
  logic        nrst, crc_valid, stream_characterisation, end_of_header, corrupt, bad_locked, rx_locked, rx_frame_start, rx_byte_stb;
  logic        rx_data_q, rx_ctrl_q, rx_tail_q, rx_err_valid, rx_len_stable, dq, cq, sseen;
  logic [1:0]  er, el, rx_err_level;
  logic [1:0]  codes [5] = '{2'h1, 2'h2, 2'h0, 2'h1, 2'h3};
  logic [7:0]  stream_payload, control_payload, rx_byte, tbyte;
  logic [15:0] dl, cl, tx_pos, ppos, rx_idx, rx_data_len, rx_ctrl_len;
  int          error_cnt = 0;
  int          cmp_count = 0;
  int          tbits = 0;
  int          tp, tf;
  gtf_link_if lk ();
  gtf_link_if lk2 ();
  // The top bit of the error byte and all sync bits but the last are damaged, so the copy loses lock and nothing else
  assign lk2.peer_stb    = lk.peer_stb;
  assign lk2.peer_bit    = lk.peer_bit ^ (corrupt && ppos >= 16'h0001 && ppos <= 16'h0003);
  assign stream_payload  = tx_pos[7:0] ^ 8'hA0;
  assign control_payload = tx_pos[7:0] ^ 8'hC0;
  always #2.5 clock = ~clock;
  gtf_dev_framer #(.FRAME_LEN(FL), .BIT_DIV(BD), .FRAME_CYC(FC)) gtf_dev_framer_i (
    .clock, .nrst, .link(lk.dev), .data_section_length(dl), .control_section_length(cl),
    .payload_length(16'h0002), .stream_err_level(er), .stream_payload, .control_payload, .tx_pos,
    .crc_valid, .crc_stream_characterisation_fail(stream_characterisation), .crc_end_of_header_fail(end_of_header), .rx_locked,
    .rx_frame_start, .rx_byte_stb, .rx_byte, .rx_idx, .rx_data_q, .rx_ctrl_q, .rx_tail_q,
    .rx_err_level, .rx_err_valid, .rx_data_len, .rx_ctrl_len, .rx_len_stable);
  gtf_dev_framer #(.FRAME_LEN(FL), .BIT_DIV(BD), .FRAME_CYC(FC)) gtf_dev_framer_flt_i (
    .clock, .nrst, .link(lk2.dev), .data_section_length(dl), .control_section_length(cl),
    .payload_length(16'h0002), .stream_err_level(er), .stream_payload, .control_payload, .tx_pos(),
    .crc_valid, .crc_stream_characterisation_fail(stream_characterisation), .crc_end_of_header_fail(end_of_header),
    .rx_locked(bad_locked), .rx_frame_start(), .rx_byte_stb(), .rx_byte(), .rx_idx(), .rx_data_q(),
    .rx_ctrl_q(), .rx_tail_q(), .rx_err_level(), .rx_err_valid(), .rx_data_len(), .rx_ctrl_len(),
    .rx_len_stable());
  gtf_peer_framer #(.FRAME_LEN(FL), .BIT_DIV(BD), .FRAME_CYC(FC)) gtf_peer_framer_i (
    .clock, .nrst, .link(lk.peer), .data_section_length(dl), .control_section_length(cl),
    .err_level(er), .section_byte(ppos[7:0] ^ 8'h3C), .pos(ppos), .sync_seen(sseen));
  gtf_link_checker #(.FRAME_LEN(FL), .BIT_DIV(BD), .FRAME_CYC(FC)) gtf_link_checker_i (
    .clock, .nrst, .dev_bit(lk.dev_bit), .dev_stb(lk.dev_stb), .peer_bit(lk.peer_bit),
    .peer_stb(lk.peer_stb));
  // ********
  // Tasks
  // ********
  task automatic chk(input string nm, input logic [39:0] seen, input logic [39:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic complete_run();
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : complete_run
  task automatic upto(input bit last);
    for (int n = 0; n < 2100; n++) begin
      @(negedge clock);
      if (last ? (rx_byte_stb === 1'b1 && rx_idx === 16'h0007) : rx_frame_start === 1'b1) begin
        return;
      end
    end
    error_cnt++;
    complete_run();
  endtask : upto
  task automatic fend();
    upto(1'b0);
    upto(1'b1);
  endtask : fend
  task automatic stat(input logic ev, input logic st);
    chk("status", {4'h0, rx_err_valid, rx_len_stable, rx_err_level, rx_data_len, rx_ctrl_len},
        {4'h0, ev, st, er, dl, cl});
  endtask : stat
  task automatic pulse(input logic [1:0] code);
    stream_characterisation       = code[0];
    end_of_header       = code[1];
    crc_valid = 1'b1;
    @(negedge clock);
    crc_valid = 1'b0;
    repeat (3) @(negedge clock);
  endtask : pulse
  // Settings change only between frames; both ends take them at frame start
  task automatic setf(input logic [15:0] d, input logic [15:0] c, input logic [1:0] e, input logic ev);
    dl = d;
    cl = c;
    er = e;
    fend();
    stat(ev, 1'b0);
    fend();
    stat(ev, 1'b1);
  endtask : setf
  function automatic logic [7:0] txe(input int p, input int f);
    logic [23:0] s;
    logic [31:0] h;
    int          d;
    s = (f % 2 == 1) ? 24'hCA_901F : 24'h35_6FE0;
    h = {dl, cl};
    d = p - 8;
    return p == 0 ? {6'h00, er} : p < 4 ? s[8 * (p - 1) +: 8] : p < 8 ? h[8 * (7 - p) +: 8] :
      d < int'(dl) ? (d < 2 ? 8'(p) ^ 8'hA0 : 8'h55) : d < int'(dl + cl) ? 8'(p) ^ 8'hC0 : 8'h55;
  endfunction : txe
  // ********
  // Monitors
  // ********
  always @(posedge clock) begin
    // The peer flags a sync only right after the last sync bit of a device frame
    if (sseen === 1'b1) begin
      chk("sync seen", 40'(tbits % (FL * 8)), 40'h20);
    end
    if (lk.dev_stb === 1'b1) begin
      tbyte = {lk.dev_bit, tbyte[7:1]};
      tbits++;
      tp    = (tbits / 8 - 1) % FL;
      tf    = (tbits - 1) / (FL * 8);
      if (tbits % 8 == 0) begin
        chk("tx byte", {32'h0, tbyte}, {32'h0, txe(tp, tf)});
      end
    end
    if (rx_byte_stb === 1'b1) begin
      dq = rx_idx < dl;
      cq = !dq && rx_idx < dl + cl;
      chk("rx flags", {36'h0, rx_locked, rx_data_q, rx_ctrl_q, rx_tail_q},
          {36'h0, 1'b1, dq, cq, !(dq || cq)});
      if (dq || cq) begin
        chk("rx byte", {32'h0, rx_byte}, {32'h0, (rx_idx[7:0] + 8'h08) ^ 8'h3C});
      end
    end
  end
  // ********
  // Sequence
  // ********
  initial begin
    nrst      = 1'b0;
    dl        = 16'h0003;
    cl        = 16'h0002;
    er        = 2'h1;
    crc_valid = 1'b0;
    stream_characterisation       = 1'b0;
    end_of_header       = 1'b0;
    corrupt   = 1'b0;
    repeat (8) @(negedge clock);
    nrst = 1'b1;
    repeat (3000) @(negedge clock);
    chk("lock two", {39'h0, rx_locked}, 40'h0);
    repeat (1400) @(negedge clock);
    chk("lock three", {39'h0, rx_locked}, 40'h1);
    fend();
    stat(1'b1, 1'b1);
    el = er;
    foreach (codes[k]) begin
      pulse(codes[k]);
      el = codes[k] > el ? codes[k] : el;
      chk("raised level", {38'h0, rx_err_level}, {38'h0, el});
    end
    fend();
    stat(1'b1, 1'b1);
    setf(16'h0000, 16'h0002, 2'h0, 1'b0);
    pulse(2'h3);
    chk("level no data", {38'h0, rx_err_level}, 40'h0);
    setf(16'h0003, 16'h0000, 2'h2, 1'b1);
    er      = 2'h3;
    corrupt = 1'b1;
    fend();
    chk("one bad sync", {39'h0, bad_locked}, 40'h1);
    fend();
    chk("two bad syncs", {39'h0, bad_locked}, 40'h0);
    complete_run();
  end
endmodule : generic_transport_framer_tb
`default_nettype wire
